//--- logic/lsd_seq.sv
`timescale 1ns/100ps
module lsd_seq
   import lsd_pkg::*;
#(
   parameter int PINS = LSD_PINS,
   parameter int PHASE_CYC = PHASE_CYC_RST
) (
   input  wire logic                 i_clk,
   input  wire logic                 i_sys_rst,
   input  wire logic                 i_enable,
   input  wire logic [PINS-1:0]      i_pin_is_com,
   input  wire logic [4:0]           i_num_com,
   input  wire logic [2:0]           i_bias_sel,
   input  wire logic [LSD_CON_W-1:0] i_contrast,
   input  wire logic [PHASE_W-1:0]   i_phase_cycles,
   input  wire logic                 i_invert,
   input  wire logic                 i_wave_low_power,
   input  wire logic [1:0]           i_drive_mode,
   input  wire logic                 i_dma_valid,
   output logic                      o_dma_ready,
   input  wire logic [PINS-1:0]      i_dma_data,
   output logic                      o_dma_req,
   output logic [PINS*LSD_LVL_W-1:0] o_pin_level,
   output logic [PINS-1:0]           o_pin_en,
   output logic [1:0]                o_drive_mode,
   output logic [LSD_CON_W-1:0]      o_contrast,
   output logic [2:0]                o_bias_sel,
   output logic [LSD_NUM_LVLS-1:0]   o_level_en,
   output logic [3:0]                o_com_index,
   output logic                      o_polarity,
   output logic                      o_frame_start
);
   // -------------------------------------------------------------
   // Configuration limits
   // -------------------------------------------------------------
   logic [3:0]         ncom_m1;
   logic [PHASE_W-1:0] phase_len;
   logic [2:0]         bias_eff;

   always_comb begin
      // Clamp so commons never exceed sixteen
      if (i_num_com == 5'h00) begin
         ncom_m1 = 4'h0;
      end else if (i_num_com > 5'h10) begin
         ncom_m1 = 4'hf; // R6
      end else begin
         ncom_m1 = 4'(i_num_com - 5'h01); // R6
      end
      // Keep phase length inside the 10..150 Hz limits for a 32-phase frame
      if (i_phase_cycles < PHASE_W'(PHASE_CYC_MIN)) begin
         phase_len = PHASE_W'(PHASE_CYC_MIN); // R11
      end else if (i_phase_cycles > PHASE_W'(PHASE_CYC_MAX)) begin
         phase_len = PHASE_W'(PHASE_CYC_MAX); // R11
      end else begin
         phase_len = i_phase_cycles; // R11
      end
      bias_eff = (i_bias_sel > 3'(LSD_BIAS_5)) ? 3'(LSD_BIAS_5)
                                               : i_bias_sel; // R8
   end

   // -------------------------------------------------------------
   // Global control timing
   // -------------------------------------------------------------
   logic [PHASE_W-1:0] tick_q;
   logic [3:0]         com_q;
   logic               pol_q;
   logic               phase_end;
   logic               frame_end;

   assign phase_end = tick_q >= phase_len - PHASE_W'(1);
   // Type A flips polarity every phase, type B once per frame
   assign frame_end = phase_end && com_q == ncom_m1;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !i_enable) begin
         tick_q <= '0;
         com_q  <= 4'h0;
         pol_q  <= 1'b0;
      end else if (phase_end) begin // R4
         tick_q <= '0;
         com_q  <= frame_end ? 4'h0 : com_q + 4'h1; // R4
         if (!i_wave_low_power || (frame_end)) begin
            pol_q <= ~pol_q; // R13
         end
      end else begin
         tick_q <= tick_q + PHASE_W'(1);
      end
   end

   // -------------------------------------------------------------
   // Display data path
   // -------------------------------------------------------------
   logic            buf_valid;
   logic            buf_ready;
   logic [PINS-1:0] buf_data;
   logic [PINS-1:0] data_q;
   logic            take;
   logic            req_q;

   lsd_buf2 #(.W(PINS)) u_buf (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_valid   (i_dma_valid), // R3
      .o_ready   (buf_ready),
      .i_data    (i_dma_data),
      .o_valid   (buf_valid),
      .i_ready   (take),
      .o_data    (buf_data)
   );

   // Swap data only as a phase ends; mid-phase words wait
   assign take = buf_valid && phase_end && i_enable; // R15

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         data_q <= '0;
      end else if (take) begin
         data_q <= i_invert ? ~buf_data : buf_data; // R12 R15
      end
   end

   // Request the next set each time a phase ends
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || !i_enable) begin
         req_q <= 1'b0;
      end else begin
         // A word taken now frees a slot even if the buffer was full
         req_q <= phase_end && (buf_ready || take); // R5
      end
   end

   // -------------------------------------------------------------
   // Bias level choice per pin
   // -------------------------------------------------------------
   // Levels: 0 ground .. 5 top of ladder; top = bias steps
   function automatic logic [2:0] lvl_of(input logic is_com,
                                         input logic on,
                                         input logic sel,
                                         input logic pol,
                                         input logic [2:0] b);
      logic [2:0] top;
      logic [2:0] l;
      top = (b == 3'(LSD_BIAS_STATIC)) ? 3'h1 : b + 3'h1;
      if (b == 3'(LSD_BIAS_STATIC)) begin
         l = is_com ? {2'h0, pol} : {2'h0, pol ^ on};
      end else if (is_com) begin
         l = sel ? (pol ? top : 3'h0)
                 : (pol ? top - 3'h1 : 3'h1);
      end else begin
         l = on ? (pol ? 3'h0 : top)
                : (pol ? top - 3'h2 : 3'h2);
         if (b == 3'(LSD_BIAS_2) && !on) begin
            l = 3'h1;
         end
      end
      return l;
   endfunction

   logic [PINS*LSD_LVL_W-1:0] lvl_d;
   logic [PINS*LSD_LVL_W-1:0] lvl_q;
   logic [PINS-1:0]           en_q;
   logic [4:0]                com_sel [PINS];

   // Commons are numbered by their order among common pins
   always_comb begin
      logic [4:0] n;
      n = 5'h00;
      for (int p = 0; p < PINS; p++) begin
         // Index 16 marks commons beyond the sixteenth
         com_sel[p] = n;
         if (i_pin_is_com[p]) begin
            n = (n == 5'h10) ? n : n + 5'h01;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < PINS; g++) begin : g_pin
         assign lvl_d[g*LSD_LVL_W +: LSD_LVL_W] =
            lvl_of(i_pin_is_com[g], data_q[g],
                   com_sel[g] == {1'b0, com_q}, pol_q,
                   bias_eff); // R1 R2
      end
   endgenerate

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         lvl_q <= '0;
         en_q  <= '0;
      end else begin
         lvl_q <= i_enable ? lvl_d : '0; // R2
         for (int p = 0; p < PINS; p++) begin
            // Surplus commons beyond the mux ratio stay undriven
            en_q[p] <= i_enable &&
                       (!i_pin_is_com[p] ||
                        com_sel[p] <= {1'b0, ncom_m1}); // R7
         end
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_drive_mode  <= LSD_DRV_RST;
         o_contrast    <= LSD_CON_RST;
         o_bias_sel    <= 3'(LSD_BIAS_STATIC);
         o_level_en    <= '0;
         o_com_index   <= 4'h0;
         o_polarity    <= 1'b0;
         o_frame_start <= 1'b0;
      end else begin
         // Mode 3 is unused; fall back to the weakest drive
         o_drive_mode  <= (i_drive_mode == 2'h3) ? 2'h0
                                                 : i_drive_mode; // R14
         o_contrast    <= i_contrast; // R10
         o_bias_sel    <= bias_eff; // R8
         o_level_en    <= i_enable ?
                          6'((7'h04 << bias_eff) - 7'h01) : '0; // R9
         o_com_index   <= com_q;
         o_polarity    <= pol_q;
         o_frame_start <= frame_end && i_enable;
      end
   end

   assign o_pin_level = lvl_q;
   assign o_pin_en    = en_q;
   assign o_dma_req   = req_q;
   assign o_dma_ready = buf_ready;
endmodule : lsd_seq

//--- logic/lsd_pkg.sv
// Operation
// (R1) Each pin configurable as common or segment
// (R2) Pin picks one of six bias levels
// (R3) Next pixel data moved in by DMA
// (R4) Control unit makes global drive signals, clocking
// (R5) Control logic requests DMA for next frame; code requests one word at every phase end
// (R6) Up to 16 multiplexed common outputs
// (R7) At most 62 common plus segment pins
// (R8) Bias static, 1/2, 1/3, 1/4, 1/5
// (R9) Up to five levels plus ground on bus
// (R10) Contrast adjustable in 64 levels
// (R11) Frame rate adjustable 10 Hz to 150 Hz; code clamps phase length only, a frame is one phase per common
// (R12) Inversion shows negative image
// (R13) Standard or low-power waveform type
// (R14) Three selectable drive modes
// (R15) New data applied only at phase boundary
package lsd_pkg;
   // -------------------------------------------------------------
   // Sizes
   // -------------------------------------------------------------
   localparam int LSD_PINS     = 62;
   localparam int LSD_MAX_COM  = 16;
   localparam int LSD_LVL_W    = 3;
   localparam int LSD_NUM_LVLS = 6;
   localparam int LSD_CON_W    = 6;
   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int CLK_HZ       = 100_000_000;
   localparam int FRAME_HZ_MIN = 10;
   localparam int FRAME_HZ_MAX = 150;
   localparam int FRAME_HZ_RST = 60;
   // Cycles per common phase at reset rate (16 phases x 2 polarities)
   localparam int PHASE_CYC_RST = CLK_HZ / (FRAME_HZ_RST * 32);
   localparam int PHASE_CYC_MIN = CLK_HZ / (FRAME_HZ_MAX * 32);
   localparam int PHASE_CYC_MAX = CLK_HZ / (FRAME_HZ_MIN * 32);
   localparam int PHASE_W       = 20;
   // -------------------------------------------------------------
   // Encodings
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      LSD_BIAS_STATIC = 3'h0,
      LSD_BIAS_2      = 3'h1,
      LSD_BIAS_3      = 3'h2,
      LSD_BIAS_4      = 3'h3,
      LSD_BIAS_5      = 3'h4
   } lsd_bias_e;
   localparam logic [1:0] LSD_DRV_RST    = 2'h0;
   localparam logic [5:0] LSD_CON_RST    = 6'h20;
   localparam logic [4:0] LSD_NCOM_RST   = 5'h04;
endpackage : lsd_pkg

//--- logic/lsd_buf2.sv
`timescale 1ns/100ps
module lsd_buf2 #(
   parameter int W = 62
) (
   input  wire logic         i_clk,
   input  wire logic         i_sys_rst,
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_data,
   output logic              o_valid,
   input  wire logic         i_ready,
   output logic [W-1:0]      o_data
);
   logic [W-1:0] mem_q [2];
   logic         wp_q;
   logic         rp_q;
   logic [1:0]   cnt_q;
   logic [1:0]   cnt_d;
   logic         ready_q;
   logic         valid_q;
   wire          push = i_valid && o_ready;
   wire          pop  = o_valid && i_ready;

   // Flags registered from the next count, so they stay flop outputs
   assign cnt_d   = cnt_q + {1'b0, push} - {1'b0, pop};
   assign o_ready = ready_q;
   assign o_valid = valid_q;
   assign o_data  = mem_q[rp_q];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wp_q] <= i_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q   <= 2'h0;
         ready_q <= 1'b1;
         valid_q <= 1'b0;
      end else begin
         ready_q <= cnt_d != 2'h2;
         valid_q <= cnt_d != 2'h0;
         if (push) begin
            wp_q <= ~wp_q;
         end
         if (pop) begin
            rp_q <= ~rp_q;
         end
         cnt_q <= cnt_d;
      end
   end
endmodule : lsd_buf2

//--- testbench/lsd_seq_assertions.sv
`timescale 1ns/100ps
module lsd_seq_checker
   import lsd_pkg::*;
#(
   parameter int PINS = LSD_PINS
) (
   input wire logic                   i_clk,
   input wire logic                   i_sys_rst,
   input wire logic                   i_enable,
   input wire logic [LSD_CON_W-1:0]   i_contrast,
   input wire logic                   o_dma_req,
   input wire logic [PINS*LSD_LVL_W-1:0] o_pin_level,
   input wire logic [PINS-1:0]        o_pin_en,
   input wire logic [1:0]             o_drive_mode,
   input wire logic [LSD_CON_W-1:0]   o_contrast,
   input wire logic [2:0]             o_bias_sel,
   input wire logic [LSD_NUM_LVLS-1:0] o_level_en,
   input wire logic                   o_frame_start
);
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic lvl_bad;
   always_comb begin
      lvl_bad = 1'b0;
      for (int p = 0; p < PINS; p++)
         if (o_pin_level[p*3+:3] > 3'h5) lvl_bad = 1'b1;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   chk_level_range: assert property (!lvl_bad)
      else $error("pin level above five");
   chk_level_set: assert property (!$past(i_sys_rst) |->
      o_level_en == ($past(i_enable) ?
                     6'((8'h4 << o_bias_sel) - 8'h1) : 6'h00))
      else $error("level enables do not match bias");
   chk_bias_max: assert property (o_bias_sel <= 3'h4)
      else $error("bias select out of range");
   chk_drive_legal: assert property (o_drive_mode != 2'h3)
      else $error("illegal drive mode");
   chk_contrast_copy: assert property ($stable(i_contrast) |=>
      o_contrast == $past(i_contrast))
      else $error("contrast not passed on");
   chk_req_pulse: assert property (o_dma_req |=> !o_dma_req)
      else $error("request longer than one cycle");
   chk_frame_pulse: assert property (o_frame_start |=> !o_frame_start)
      else $error("frame pulse too long");
   chk_pins_off: assert property (!i_enable [*2] |=> o_pin_en == '0)
      else $error("pins driven while stopped");
endmodule : lsd_seq_checker
bind lsd_seq lsd_seq_checker #(.PINS(PINS)) lsd_seq_checker_i (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_enable(i_enable),
   .i_contrast(i_contrast), .o_dma_req(o_dma_req),
   .o_pin_level(o_pin_level), .o_pin_en(o_pin_en),
   .o_drive_mode(o_drive_mode), .o_contrast(o_contrast),
   .o_bias_sel(o_bias_sel), .o_level_en(o_level_en),
   .o_frame_start(o_frame_start));

//--- testbench/lsd_dma_src.sv
`timescale 1ns/100ps
module lsd_dma_src (
   input  wire logic   i_clk,
   input  wire logic   i_sys_rst,
   input  wire logic   i_dma_req,
   input  wire logic   i_kick,
   input  wire logic   i_stall,
   input  wire logic   i_dma_ready,
   output logic        o_dma_valid,
   output logic [61:0] o_dma_data,
   output logic [7:0]  o_sent
);
   // ------------------------------------------------------------
   // Display buffer source
   // ------------------------------------------------------------
   logic [7:0] pend_q;
   logic       start;
   assign start = !o_dma_valid && pend_q != 8'h00 && !i_stall;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pend_q      <= 8'h00;
         o_dma_valid <= 1'b0;
         o_dma_data  <= '1;
         o_sent      <= 8'h00;
      end else begin
         pend_q <= pend_q + {7'h0, i_dma_req} + {7'h0, i_kick}
                 - {7'h0, start};
         if (o_dma_valid && i_dma_ready) begin
            o_dma_valid <= 1'b0;
            // Released: no stale word left on the bus
            o_dma_data  <= ~o_dma_data;
            o_sent      <= o_sent + 8'h01;
         end else if (start) begin
            o_dma_valid <= 1'b1;
            o_dma_data  <= {31{2'b10}} ^ {54'h0, o_sent};
         end
      end
   end
endmodule : lsd_dma_src

//--- testbench/test_lsd_seq.sv
`timescale 1ns/100ps
module test_lsd_seq
   import lsd_pkg::*;
;
   // ------------------------------------------------------------
   // Bench
   // ------------------------------------------------------------
   logic i_clk, i_sys_rst = 1'b1, i_enable = 1'b0, i_invert = 1'b0;
   logic i_wave_low_power = 1'b0, kick = 1'b0, stall = 1'b0;
   logic [LSD_PINS-1:0]  i_pin_is_com = 62'h1;
   logic [4:0]           i_num_com = 5'h01;
   logic [2:0]           i_bias_sel = 3'h0;
   logic [LSD_CON_W-1:0] i_contrast = 6'h20;
   logic [1:0]           i_drive_mode = 2'h0;
   logic [PHASE_W-1:0]   i_phase_cycles = 20'h0;
   logic dma_valid, dma_ready, dma_req, fstart, pol;
   logic [LSD_PINS-1:0]   dma_data, pin_en;
   logic [LSD_PINS*3-1:0] pin_level;
   logic [1:0] drv;
   logic [5:0] con, lvl_en;
   logic [2:0] bias;
   logic [3:0] com_idx;
   logic [7:0] sent;
   int failures = 0, num_checks = 0, reqs = 0, n, e;
   lsd_seq #(.PINS(LSD_PINS)) lsd_seq_i (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_enable(i_enable),
      .i_pin_is_com(i_pin_is_com), .i_num_com(i_num_com),
      .i_bias_sel(i_bias_sel), .i_contrast(i_contrast),
      .i_phase_cycles(i_phase_cycles), .i_invert(i_invert),
      .i_wave_low_power(i_wave_low_power), .i_drive_mode(i_drive_mode),
      .i_dma_valid(dma_valid), .o_dma_ready(dma_ready),
      .i_dma_data(dma_data), .o_dma_req(dma_req), .o_pin_level(pin_level),
      .o_pin_en(pin_en), .o_drive_mode(drv), .o_contrast(con),
      .o_bias_sel(bias), .o_level_en(lvl_en), .o_com_index(com_idx),
      .o_polarity(pol), .o_frame_start(fstart));
   lsd_dma_src lsd_dma_src_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_dma_req(dma_req), .i_kick(kick), .i_stall(stall),
      .i_dma_ready(dma_ready), .o_dma_valid(dma_valid),
      .o_dma_data(dma_data), .o_sent(sent));
   task automatic check_val(input string what, input logic [63:0] exp,
                            input logic [63:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val
   task automatic kick_word();
      @(posedge i_clk);
      kick <= 1'b1;
      @(posedge i_clk);
      kick <= 1'b0;
   endtask : kick_word
   task automatic wait_rise(ref logic sig, input int lim, output int k);
      k = 0;
      do begin
         @(negedge i_clk);
         k++;
      end while (sig !== 1'b1 && k < lim);
      if (k >= lim) failures++;
   endtask : wait_rise
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   always @(negedge i_clk) if (dma_req === 1'b1) reqs++;
   // Two frame waits of about 20833 cycles each dominate the run
   initial begin
      repeat (100000) @(posedge i_clk);
      failures++;
      finish_test();
   end
   initial begin
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      check_val("ready at reset", 64'h1, dma_ready);
      check_val("contrast at reset", 64'h20, con);
      check_val("pins at reset", 64'h0, pin_en);
      @(posedge i_clk);
      i_sys_rst <= 1'b0;
      $display("test reset done");
      for (int b = 0; b < 8; b++) begin
         @(posedge i_clk);
         i_bias_sel <= 3'(b);
         i_drive_mode <= 2'(b);
         i_contrast <= 6'(b * 9);
         repeat (2) @(posedge i_clk);
         @(negedge i_clk);
         e = (b > 4) ? 4 : b;
         check_val("bias", e, bias);
         // Ladder stays off while the display is stopped
         check_val("levels", 64'h0, lvl_en);
         check_val("drive", (b % 4 == 3) ? 0 : b % 4, drv);
         check_val("contrast", b * 9, con);
      end
      $display("test config done");
      @(posedge i_clk);
      stall <= 1'b1;
      repeat (3) kick_word();
      @(posedge i_clk);
      stall <= 1'b0;
      repeat (10) @(posedge i_clk);
      @(negedge i_clk);
      check_val("words taken", 2, sent);
      check_val("ready when full", 0, dma_ready);
      check_val("word held", 1, dma_valid);
      $display("test buffer done");
      @(posedge i_clk);
      i_enable <= 1'b1;
      i_wave_low_power <= 1'b1;
      wait_rise(fstart, 45000, n);
      wait_rise(fstart, 45000, n);
      check_val("frame spacing", PHASE_CYC_MIN, n);
      check_val("levels run", 64'h3f, lvl_en);
      check_val("polarity", 1, pol);
      check_val("com index", 0, com_idx);
      check_val("common level", 5, pin_level[2:0]);
      check_val("pins driven", {2'b00, {62{1'b1}}}, pin_en);
      check_val("requests", 1, reqs > 0);
      check_val("nothing lost", 1, sent >= 8'h03);
      $display("test run done");
      finish_test();
   end
endmodule : test_lsd_seq
